// ### hdl/alarm_pkg.sv
// constants and types shared by the alarm controller
// assumes a single slow clock domain
package alarm_pkg;
  // ****************************************
  // state codes, bit order clear/select/beacon
  // ****************************************
  typedef enum logic [2:0] {
    IDLE_STATE          = 3'h7,
    ARMING_STATE        = 3'h1,
    ARMED_STATE         = 3'h5,
    ENTRY_DELAY_STATE   = 3'h3,
    ALARM_STATE         = 3'h2,
    LATCHED_ALARM_STATE = 3'h4
  } alarm_state_e;
  localparam int CLEAR_BIT   = 2;
  localparam int SELECT_BIT  = 1;
  localparam int BEACON_BIT  = 0;
  // ****************************************
  // delay counter
  // ****************************************
  localparam int CNT_W       = 10;
  localparam int ENTRY_TAP   = 6;  // counter bit 7, numbered from 1
  localparam int TIMEOUT_TAP = 9;  // counter bit 10, numbered from 1
  localparam int CLK_HZ      = 20000000;
  localparam logic SOUNDER_ON  = 1'b0;
  localparam logic SOUNDER_OFF = 1'b1;
  localparam int SYNC_STAGES = 3;
endpackage

// ### hdl/alarm_sync.sv
// three flop synchroniser with agreement filter for one pin
// assumes an asynchronous pin and the system clock
`timescale 1ns/10ps
module alarm_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  import alarm_pkg::*;
  logic [SYNC_STAGES-1:0] sh_reg;
  logic [SYNC_STAGES-1:0] sh_next;
  logic                   level_next;
  always_comb begin
    sh_next = {sh_reg[SYNC_STAGES-2:0], pin_i};
    level_next = level_o;
    // first stage never looked at directly
    if (sh_reg[1] == sh_reg[2]) begin
      level_next = sh_reg[1];
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // reset low, not high: a high start would read as fire and attack
      sh_reg  <= '0;
      level_o <= 1'b0;
    end else begin
      sh_reg  <= sh_next;
      level_o <= level_next;
    end
  end
endmodule

// ### hdl/alarm_controller_fsm.sv
// six state alarm controller with delay counter
// assumes detect inputs are active high pins; slow nominal clock
`timescale 1ns/10ps
// Functional notes
// - states coded clear/select/beacon: 111,001,101,011,010,100.
// - reset puts every fsm register high, synchronisers low: idle, outputs inactive.
// - counter cleared in idle, armed, latched; runs otherwise.
// - beacon is active low, asserted in alarm and latched states.
// - sounder active low: 0 on, 1 off.
// - entry delay from counter bit 7, sounder timeout from bit 10.
// - idle: arm alone to arming; fire or attack to latched, sounder on.
// - arming to armed on bit 7, no fire, arm or reset.
// - armed: timed loop to entry delay, untimed loop to alarm sounding.
// - entry delay: bit 7 or untimed loop, no fire, to alarm sounding.
// - alarm to latched, sounder off, on bit 10, no fire, arm or reset.
// - fire in any active state goes latched with sounder on.
// - arm and reset low, no fire, returns any non-idle state to idle, sounder off.
// - counter increments while enabled, synchronous clear on clear bit.
// - sounder holds its value where no action is named.
module alarm_controller_fsm #(
  parameter int CNT_WIDTH = alarm_pkg::CNT_W
) (
  input  wire logic SYS_CLK_I,
  input  wire logic RST_I,
  input  wire logic ARM_I,
  input  wire logic RESET_SW_I,
  input  wire logic FIRE_I,
  input  wire logic ATTACK_I,
  input  wire logic TIMED_LOOP_A_I,
  input  wire logic TIMED_LOOP_B_I,
  input  wire logic UNTIMED_LOOP_A_I,
  input  wire logic UNTIMED_LOOP_B_I,
  input  wire logic UNTIMED_LOOP_C_I,
  output logic      SOUNDER_N_O,
  output logic      BEACON_N_O,
  output logic [2:0] STATE_O
);
  import alarm_pkg::*;
  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int N_IN = 9;
  logic [N_IN-1:0] raw_pins;
  logic [N_IN-1:0] sync_lvl;
  assign raw_pins = {ARM_I, RESET_SW_I, FIRE_I, ATTACK_I, TIMED_LOOP_A_I,
                     TIMED_LOOP_B_I, UNTIMED_LOOP_A_I, UNTIMED_LOOP_B_I,
                     UNTIMED_LOOP_C_I};
  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_sync
      alarm_sync u_sync (
        .clk_i   (SYS_CLK_I),
        .rst_i   (RST_I),
        .pin_i   (raw_pins[g]),
        .level_o (sync_lvl[g])
      );
    end
  endgenerate
  logic arm, rst_sw, fire, attack, timed_any, untimed_any, disarm, keep_on;
  // inputs taken as active high by design; inversion belongs upstream
  assign arm         = sync_lvl[8];
  assign rst_sw      = sync_lvl[7];
  assign fire        = sync_lvl[6];
  assign attack      = sync_lvl[5];
  assign timed_any   = sync_lvl[4] | sync_lvl[3];
  assign untimed_any = sync_lvl[2] | sync_lvl[1] | sync_lvl[0];
  assign disarm      = ~arm & ~rst_sw;
  assign keep_on     = arm | rst_sw;
  // ****************************************
  // state machine and sounder
  // ****************************************
  alarm_state_e state_reg, state_next;
  logic         sounder_reg, sounder_next;
  logic [CNT_WIDTH-1:0] cnt_reg, cnt_next;
  logic entry_delay_tap, sounder_timeout_tap;
  // delays are taps of the counter, cheaper than per-state timers
  assign entry_delay_tap     = cnt_reg[ENTRY_TAP];
  assign sounder_timeout_tap = cnt_reg[TIMEOUT_TAP];
  always_comb begin
    state_next   = state_reg;
    sounder_next = sounder_reg;
    case (state_reg)
      IDLE_STATE: begin
        if (attack | fire) begin
          state_next   = LATCHED_ALARM_STATE;
          sounder_next = SOUNDER_ON;
        end else if (arm) begin
          state_next = ARMING_STATE;
        end
      end
      ARMING_STATE: begin
        if (fire) begin
          state_next   = LATCHED_ALARM_STATE;
          sounder_next = SOUNDER_ON;
        end else if (disarm) begin
          state_next   = IDLE_STATE;
          sounder_next = SOUNDER_OFF;
        end else if (entry_delay_tap) begin
          state_next = ARMED_STATE;
        end
      end
      ARMED_STATE: begin
        if (fire) begin
          state_next   = LATCHED_ALARM_STATE;
          sounder_next = SOUNDER_ON;
        end else if (disarm) begin
          state_next   = IDLE_STATE;
          sounder_next = SOUNDER_OFF;
        end else if (untimed_any) begin
          state_next   = ALARM_STATE;
          sounder_next = SOUNDER_ON;
        end else if (timed_any) begin
          state_next = ENTRY_DELAY_STATE;
        end
      end
      ENTRY_DELAY_STATE: begin
        if (fire) begin
          state_next   = LATCHED_ALARM_STATE;
          sounder_next = SOUNDER_ON;
        end else if (disarm) begin
          state_next   = IDLE_STATE;
          sounder_next = SOUNDER_OFF;
        end else if (entry_delay_tap | untimed_any) begin
          state_next   = ALARM_STATE;
          sounder_next = SOUNDER_ON;
        end
      end
      ALARM_STATE: begin
        if (fire) begin
          state_next   = LATCHED_ALARM_STATE;
          sounder_next = SOUNDER_ON;
        end else if (disarm) begin
          state_next   = IDLE_STATE;
          sounder_next = SOUNDER_OFF;
        end else if (sounder_timeout_tap & keep_on) begin
          state_next   = LATCHED_ALARM_STATE;
          sounder_next = SOUNDER_OFF;
        end
      end
      LATCHED_ALARM_STATE: begin
        // only way out, fire or attack sounder stays until disarm
        if (disarm) begin
          state_next   = IDLE_STATE;
          sounder_next = SOUNDER_OFF;
        end
      end
      default: begin
        state_next   = IDLE_STATE;
        sounder_next = SOUNDER_OFF;
      end
    endcase
  end
  // ****************************************
  // delay counter
  // ****************************************
  always_comb begin
    if (state_reg[CLEAR_BIT]) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg   <= IDLE_STATE;
      sounder_reg <= SOUNDER_OFF;
      cnt_reg     <= '1;
      SOUNDER_N_O <= SOUNDER_OFF;
      BEACON_N_O  <= 1'b1;
      STATE_O     <= IDLE_STATE;
    end else begin
      state_reg   <= state_next;
      sounder_reg <= sounder_next;
      cnt_reg     <= cnt_next;
      SOUNDER_N_O <= sounder_next;
      BEACON_N_O  <= state_next[BEACON_BIT];
      STATE_O     <= state_next;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  a_beacon_state: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (BEACON_N_O == 1'b0) == (state_reg == ALARM_STATE
      || state_reg == LATCHED_ALARM_STATE))
    else $error("beacon disagrees with state");
  a_counter_clear: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    $past(state_reg[CLEAR_BIT]) && !$past(RST_I) |-> cnt_reg == '0)
    else $error("counter not cleared");
  a_counter_runs: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !state_reg[CLEAR_BIT] |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("counter did not advance");
  a_fire_latch: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    fire && state_reg != IDLE_STATE && state_reg != LATCHED_ALARM_STATE
    |=> state_reg == LATCHED_ALARM_STATE && SOUNDER_N_O == 1'b0)
    else $error("fire not latched");
  a_disarm_idle: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    disarm && !fire && state_reg != IDLE_STATE
    |=> state_reg == IDLE_STATE && SOUNDER_N_O == 1'b1)
    else $error("disarm did not return idle");
  a_idle_arm: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    state_reg == IDLE_STATE && arm && !fire && !attack
    |=> state_reg == ARMING_STATE)
    else $error("arm not taken");
  a_arming_done: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    state_reg == ARMING_STATE && entry_delay_tap && !fire && keep_on
    |=> state_reg == ARMED_STATE)
    else $error("arming did not finish");
  a_timeout_off: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    state_reg == ALARM_STATE && sounder_timeout_tap && !fire && keep_on
    |=> state_reg == LATCHED_ALARM_STATE && SOUNDER_N_O == 1'b1)
    else $error("sounder timeout missed");
  a_hold_quiet: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    state_reg == LATCHED_ALARM_STATE && !disarm
    |=> $stable(state_reg) && $stable(SOUNDER_N_O))
    else $error("latched state moved");
  c_entry_alarm: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
    state_reg == ENTRY_DELAY_STATE ##1 state_reg == ALARM_STATE);
  c_timeout: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
    state_reg == ALARM_STATE ##1 state_reg == LATCHED_ALARM_STATE && SOUNDER_N_O);
  c_fire: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
    state_reg == IDLE_STATE ##1 state_reg == LATCHED_ALARM_STATE);
  c_fire_entry: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
    state_reg == ENTRY_DELAY_STATE ##1 state_reg == LATCHED_ALARM_STATE);
endmodule

// ### dv/alarm_field.sv
// field side model: switches and transducers facing the controller
// assumes the bench sets one alarm condition per bit, 1 = condition present
`timescale 1ns/10ps
module alarm_field #(
  parameter logic [8:0] LOW_ACTIVE = 9'h000
) (
  input  wire logic       clk_i,
  input  wire logic [8:0] cond_i,
  output logic      [8:0] pins_o
);
  // ********
  // transducer levels
  // ********
  logic [8:0] sensor_reg;
  // low-active sensors need inverting so every pin reads one on alarm
  always_ff @(posedge clk_i) begin
    sensor_reg <= cond_i ^ LOW_ACTIVE;
  end
  assign pins_o = sensor_reg ^ LOW_ACTIVE;
endmodule

// ### dv/testbench.sv
// self-checking bench for the alarm controller
// assumes the field model drives every detect and switch pin
`timescale 1ns/10ps
module testbench;
  logic       sys_clk, rst, sounder_n, beacon_n;
  logic [8:0] cond, pins;
  logic [2:0] state;
  int         num_errors, samples_checked, u;
  integer     seed;
  localparam logic [2:0] S_IDLE = 3'h7, S_ARMING = 3'h1, S_ARMED = 3'h5;
  localparam logic [2:0] S_ENTRY = 3'h3, S_ALARM = 3'h2, S_LATCH = 3'h4;
  // ********
  // clock, model, design
  // ********
  // 50 ns period, the 20 MHz of CLK_HZ; delays checked in cycles
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // fire pin from a low-active smoke sensor, inverted in the model
  alarm_field #(.LOW_ACTIVE(9'h004)) u_alarm_field (
    .clk_i(sys_clk), .cond_i(cond), .pins_o(pins));
  alarm_controller_fsm u_alarm_controller_fsm (
    .SYS_CLK_I(sys_clk), .RST_I(rst), .ARM_I(pins[0]), .RESET_SW_I(pins[1]),
    .FIRE_I(pins[2]), .ATTACK_I(pins[3]), .TIMED_LOOP_A_I(pins[4]),
    .TIMED_LOOP_B_I(pins[5]), .UNTIMED_LOOP_A_I(pins[6]),
    .UNTIMED_LOOP_B_I(pins[7]), .UNTIMED_LOOP_C_I(pins[8]),
    .SOUNDER_N_O(sounder_n), .BEACON_N_O(beacon_n), .STATE_O(state));
  // ********
  // tasks
  // ********
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic set_cond(input logic [8:0] v);
    @(posedge sys_clk);
    cond <= v;
  endtask
  // waits bounded; lo/hi give the legal window in cycles
  task automatic wait_state(input logic [2:0] exp, input int lo, input int hi);
    int n;
    n = 0;
    while (state !== exp && n <= hi) begin
      @(negedge sys_clk);
      n++;
    end
    check({9'h0, state}, {9'h0, exp});
    check({11'h0, (n >= lo) && (n <= hi)}, 12'h001);
  endtask
  task automatic check_out(input logic snd_n, input logic bcn_n);
    check({10'h0, sounder_n, beacon_n}, {10'h0, snd_n, bcn_n});
  endtask
  task automatic go_armed;
    set_cond(9'h001);
    wait_state(S_ARMING, 1, 10);
    wait_state(S_ARMED, 62, 70);
    check_out(1'b1, 1'b1);
  endtask
  task automatic disarm;
    set_cond(9'h000);
    wait_state(S_IDLE, 1, 10);
    check_out(1'b1, 1'b1);
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ********
  // watchdog
  // ********
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end
  // ********
  // tests
  // ********
  initial begin
    seed = 79903;
    cond = 9'h000;
    rst = 1'b1;
    num_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check({9'h0, state}, {9'h0, S_IDLE});
    check_out(1'b1, 1'b1);
    $display("test reset done");
    // panic with arm also set: panic must win, then hold while arm stays
    for (int k = 2; k <= 3; k++) begin
      set_cond(9'h001 | (9'h001 << k));
      wait_state(S_LATCH, 1, 10);
      check_out(1'b0, 1'b0);
      set_cond(9'h001);
      repeat (20) @(negedge sys_clk);
      check({9'h0, state}, {9'h0, S_LATCH});
      check_out(1'b0, 1'b0);
      disarm();
    end
    $display("test panic done");
    // timed loop, random side, entry delay then sounder timeout
    go_armed();
    set_cond(9'h001 | (9'h010 << ($unsigned($random(seed)) % 2)));
    wait_state(S_ENTRY, 1, 10);
    wait_state(S_ALARM, 62, 70);
    check_out(1'b0, 1'b0);
    wait_state(S_LATCH, 440, 455);
    check_out(1'b1, 1'b0);
    disarm();
    $display("test timed done");
    // every untimed loop, first in random order, sounder timeout on one
    u = $unsigned($random(seed)) % 3;
    for (int k = 0; k < 3; k++) begin
      go_armed();
      set_cond(9'h003 | (9'h040 << ((u + k) % 3)));
      wait_state(S_ALARM, 1, 10);
      check_out(1'b0, 1'b0);
      if (k == 0) begin
        wait_state(S_LATCH, 505, 520);
        check_out(1'b1, 1'b0);
      end
      disarm();
    end
    $display("test untimed done");
    // fire from armed, entry delay and alarm; untimed loop ends entry early
    for (int k = 0; k < 3; k++) begin
      go_armed();
      if (k > 0) begin
        set_cond(9'h011);
        wait_state(S_ENTRY, 1, 10);
      end
      if (k == 2) begin
        set_cond(9'h111);
        wait_state(S_ALARM, 1, 10);
        check_out(1'b0, 1'b0);
      end
      set_cond(cond | 9'h004);
      wait_state(S_LATCH, 1, 10);
      check_out(1'b0, 1'b0);
      disarm();
    end
    $display("test fire states done");
    // reset switch alone keeps arming going; both low in entry returns idle
    set_cond(9'h001);
    wait_state(S_ARMING, 1, 10);
    set_cond(9'h002);
    wait_state(S_ARMED, 60, 66);
    set_cond(9'h022);
    wait_state(S_ENTRY, 1, 10);
    set_cond(9'h020);
    wait_state(S_IDLE, 1, 10);
    check_out(1'b1, 1'b1);
    $display("test reset switch done");
    // fire while arming, then a reset in mid-run
    set_cond(9'h001);
    wait_state(S_ARMING, 1, 10);
    set_cond(9'h005);
    wait_state(S_LATCH, 1, 10);
    check_out(1'b0, 1'b0);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(negedge sys_clk);
    check({9'h0, state}, {9'h0, S_IDLE});
    check_out(1'b1, 1'b1);
    set_cond(9'h000);
    rst <= 1'b0;
    repeat (8) @(negedge sys_clk);
    check({9'h0, state}, {9'h0, S_IDLE});
    check_out(1'b1, 1'b1);
    $display("test fire done");
    close_out();
  end
endmodule
